// ### core/cpd_pkg.sv
// constants and types for the coincidence pulse digitizer control
// assumes a single 125 MHz system clock and active-low async reset
package cpd_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned CH_NUM         = 2;

  // delay of each channel pulse before the linear gate, in ns
  localparam int unsigned GATE_DELAY_NS  = 3000;
  localparam int unsigned GATE_DELAY_CYC = GATE_DELAY_NS / CLK_PERIOD_NS;
  // settle time from shaper active until a tick may set busy, in ns
  localparam int unsigned SETTLE_NS      = 4000;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // delay of the first-and-second coincidence, in ns
  localparam int unsigned COINC_DLY_NS   = 1000;
  localparam int unsigned COINC_DLY_CYC  = COINC_DLY_NS / CLK_PERIOD_NS;
  // linear gate opening pulse width, in ns
  localparam int unsigned OPEN_NS        = 5000;
  localparam int unsigned OPEN_CYC       = OPEN_NS / CLK_PERIOD_NS;
  // conversion tick period: 500 kc, 2 us per tick = one count per 10 mV
  localparam int unsigned TICK_NS        = 2000;
  localparam int unsigned TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
  // linear range: 2.56 V / 10 mV
  localparam int unsigned FULL_SCALE     = 256;

  localparam int unsigned CNT_W          = 10;
  localparam int unsigned DLY_W          = 9;

  localparam logic [CNT_W-1:0] CNT_ZERO  = 10'h000;

endpackage

// ### core/cpd_delay.sv
// fixed-length shift delay of a single level, one bit per system cycle
// assumes depth of at least one
module cpd_delay #(
  parameter int unsigned DEPTH = 375
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // data
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] sr_q;
  logic [DEPTH-1:0] sr_d;

  always_comb begin
    if (DEPTH > 1) begin
      sr_d = {sr_q[DEPTH-2:0], din};
    end else begin
      sr_d = {DEPTH{din}};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sr_q <= '0;
    end else begin
      sr_q <= sr_d;
    end
  end

  assign dout = sr_q[DEPTH-1];
endmodule

// ### core/cpd_top.sv
// control logic of a two-channel coincidence pulse height digitizer
// assumes threshold hits and shaper levels synchronous to clk_sys,
// and an encoder that drives set request and sync as levels
//
// Functional notes
// - channel pulse delayed 3 us before gate
// - linear gate passes only during gating pulse
// - shaper active 4 us before busy set
// - conversion interval starts at busy rising edge
// - burst ticks only while shaper and busy
// - one tick per 2 us, range 256
// - busy rests cleared; coincidence only when clear
// - tick with either shaper sets busy
// - one shared 500 kc tick for all
// - hit pulse per channel above threshold
// - first-and-second coincidence, 1 us delay, third veto
// - gate opening only while busy clear
module cpd_top (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // threshold detector outputs, one per channel
  input  wire logic [2:0]           thr_hit,
  // channel pulses arriving for the linear gates
  input  wire logic [1:0]           ch_pulse,
  // converter shaper outputs, high while held amplitude decays
  input  wire logic [1:0]           shaper_act,
  // telemetry encoder
  input  wire logic                 enc_set_req,
  input  wire logic                 enc_sync,
  // linear gate side
  output logic [1:0]                gate_out,
  output logic                      gate_open,
  output logic                      discharge,
  // converter outputs to the encoder
  output logic [1:0]                burst,
  output logic                      busy,
  output logic                      tick
);
  import cpd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // shared 500 kc tick
  logic [DLY_W-1:0] tick_cnt_q, tick_cnt_d;
  logic             tick_q, tick_d;

  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 9'h001;
    if (tick_cnt_q == DLY_W'(TICK_CYC - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end
  assign tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // hits and coincidence
  logic [2:0] hit_q, hit_d;
  logic       ab_dly;
  logic       abc_n;

  always_comb begin
    hit_d = thr_hit;
  end

  cpd_delay #(.DEPTH(COINC_DLY_CYC)) u_coinc_dly (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (hit_q[0] & hit_q[1]),
    .dout    (ab_dly)
  );

  // third channel vetoes at acceptance time
  assign abc_n = ab_dly & ~hit_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // busy flag and gate opening pulse
  logic             busy_q, busy_d;
  logic             sync_q, sync_d;
  logic [CNT_W-1:0] open_cnt_q, open_cnt_d;
  logic             open_q, open_d;
  logic [1:0]       settled;
  logic             sync_fall;

  assign sync_fall = sync_q & ~enc_sync;

  always_comb begin
    sync_d = enc_sync;
    busy_d = busy_q;
    // set wins over the sync clear so no conversion is lost
    if (sync_fall) begin
      busy_d = 1'b0;
    end
    if (enc_set_req || (tick_q && |(shaper_act & settled))) begin
      busy_d = 1'b1;
    end
  end

  always_comb begin
    open_d     = open_q;
    open_cnt_d = open_cnt_q;
    // 625 cycles overflow a 9-bit count, so this one is wider
    if (open_q) begin
      if (open_cnt_q == CNT_ZERO) begin
        open_d = 1'b0;
      end else begin
        open_cnt_d = open_cnt_q - 10'h001;
      end
    end else if (abc_n && !busy_q) begin
      open_d     = 1'b1;
      open_cnt_d = CNT_W'(OPEN_CYC - 1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hit_q      <= '0;
      busy_q     <= 1'b0;
      sync_q     <= 1'b0;
      open_q     <= 1'b0;
      open_cnt_q <= '0;
    end else begin
      hit_q      <= hit_d;
      busy_q     <= busy_d;
      sync_q     <= sync_d;
      open_q     <= open_d;
      open_cnt_q <= open_cnt_d;
    end
  end
  assign busy      = busy_q;
  assign gate_open = open_q;
  // discharge begins at busy rising edge and runs while busy
  assign discharge = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // per channel: input delay, linear gate, settle count, burst gate
  logic [1:0] pulse_dly;
  logic [1:0] gate_q, gate_d;
  logic [1:0] burst_q, burst_d;

  for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
    logic [DLY_W-1:0] set_cnt_q, set_cnt_d;

    cpd_delay #(.DEPTH(GATE_DELAY_CYC)) u_in_dly (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (ch_pulse[i]),
      .dout    (pulse_dly[i])
    );

    // held amplitude must settle before a tick may set busy
    always_comb begin
      set_cnt_d = '0;
      if (shaper_act[i]) begin
        set_cnt_d = (set_cnt_q == DLY_W'(SETTLE_CYC)) ? set_cnt_q : set_cnt_q + 9'h001;
      end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        set_cnt_q <= '0;
      end else begin
        set_cnt_q <= set_cnt_d;
      end
    end
    assign settled[i] = (set_cnt_q == DLY_W'(SETTLE_CYC));
  end

  always_comb begin
    gate_d  = pulse_dly & {2{open_q}};
    burst_d = {2{tick_q & busy_q}} & shaper_act;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_q  <= '0;
      burst_q <= '0;
    end else begin
      gate_q  <= gate_d;
      burst_q <= burst_d;
    end
  end
  assign gate_out = gate_q;
  assign burst    = burst_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  // helper count of the gate pulse length for the length check
  logic [CNT_W-1:0] open_len_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      open_len_q <= CNT_ZERO;
    end else begin
      open_len_q <= open_q ? open_len_q + 10'h001 : CNT_ZERO;
    end
  end

  open_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(open_q) |-> open_len_q == CNT_W'(OPEN_CYC))
    else $error("gate pulse length wrong");

  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    enc_set_req |=> busy_q)
    else $error("busy not set by set request");

  sync_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sync_q && !enc_sync && !enc_set_req && !(tick_q && |(shaper_act & settled)))
      |=> !busy_q)
    else $error("busy not cleared by sync");

  open_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!open_q && busy_q) |=> !open_q)
    else $error("gate opened while busy");

  open_width_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(open_q) |-> open_q [*8])
    else $error("gate pulse too short");

  gate_closed_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !open_q |=> gate_q == 2'b00)
    else $error("linear gate open without gating pulse");

  burst_cond_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    |burst_q |-> $past(busy_q) && $past(tick_q))
    else $error("burst outside busy");

  tick_period_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick_q |=> !tick_q [*8])
    else $error("tick too frequent");

  tick_due_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick_q |-> ##[1:250] tick_q)
    else $error("tick missing");

  settle_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!busy_q && !enc_set_req && !(|settled)) |=> !busy_q)
    else $error("busy set before settle");

  veto_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!open_q && hit_q[2]) |=> !open_q)
    else $error("opening despite third channel");

  open_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(open_q));
  busy_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(busy_q));
  burst_c: cover property (@(posedge clk_sys) disable iff (!resetn) burst_q == 2'b11);
  clear_c: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(busy_q));
endmodule

// ### bench/cpd_enc_model.sv
// telemetry encoder model: counts bursts, forces and clears busy
// assumes one clk_sys domain, signals changed just after the edge
module cpd_enc_model (
  // clock
  input  wire logic       clk_sys,
  // bursts from the converter
  input  wire logic [1:0] burst,
  // busy control
  output logic            enc_set_req,
  output logic            enc_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  int scaler [2];
  initial begin
    enc_set_req = 1'b0;
    enc_sync    = 1'b0;
    scaler      = '{0, 0};
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      scaler[i] += burst[i];
    end
  end
  // set is dropped before sync falls, since set wins over clear
  task automatic readout(input int n);
    @(posedge clk_sys);
    #1;
    enc_set_req = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1;
    enc_set_req = 1'b0;
    enc_sync    = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    enc_sync = 1'b0;
    scaler   = '{0, 0};
  endtask
endmodule

// ### bench/test_coincidence_pulse_digitizer.sv
// self-checking bench for the digitizer control
// assumes the encoder model beside it and cpd_pkg counts
module test_coincidence_pulse_digitizer;
  timeunit 1ns;
  timeprecision 1ps;
  import cpd_pkg::*;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] thr_hit = 3'h0;
  logic [1:0] ch_pulse = 2'h0;
  logic [1:0] shaper_act = 2'h0;
  logic       enc_set_req, enc_sync, gate_open, discharge, busy, tick;
  logic [1:0] gate_out, burst, m;
  logic [31:0] rnd = 32'h1bd7;
  int         bad_count = 0;
  int         num_checks = 0;
  int         n0, n1, ng, k, t;
  int         exp_q [$];
  always #4 clk_sys = ~clk_sys;
  cpd_top cpd_top_inst (.clk_sys(clk_sys), .resetn(resetn), .thr_hit(thr_hit),
    .ch_pulse(ch_pulse), .shaper_act(shaper_act), .enc_set_req(enc_set_req),
    .enc_sync(enc_sync), .gate_out(gate_out), .gate_open(gate_open),
    .discharge(discharge), .burst(burst), .busy(busy), .tick(tick));
  cpd_enc_model cpd_enc_model_inst (.clk_sys(clk_sys), .burst(burst),
    .enc_set_req(enc_set_req), .enc_sync(enc_sync));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_cnt(input string what, input int e, input int g);
    num_checks++;
    if (g != e) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // counts gate activity over a window, busy mirror checked each cycle
  task automatic watch(input int n);
    n0 = 0;
    n1 = 0;
    ng = 0;
    repeat (n) begin
      step(1);
      n0 += int'(gate_out[0] === 1'b1);
      n1 += int'(gate_out[1] === 1'b1);
      ng += int'(gate_open === 1'b1);
      chk_bit("discharge", busy, discharge);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    wrap_up;
  end
  initial begin
    step(10);
    resetn = 1'b1;
    chk_bit("busy_rest", 1'b0, busy);
    t = 0;
    while (tick !== 1'b1 && t < 600) begin
      step(1);
      t++;
    end
    step(1);
    t = 1;
    while (tick !== 1'b1 && t < 600) begin
      step(1);
      t++;
    end
    chk_cnt("tick_period", TICK_CYC, t);
    // late pulse on channel 1 shows the line delay before the gate
    ch_pulse = 2'b01;
    step(400);
    thr_hit  = 3'b011;
    ch_pulse = 2'b11;
    step(4);
    thr_hit = 3'h0;
    watch(900);
    chk_cnt("open_len", OPEN_CYC, ng);
    chk_cnt("gate0_len", OPEN_CYC, n0);
    chk_bit("gate1_delayed", 1'b1, n1 > 300 && n1 < 450);
    ch_pulse = 2'h0;
    thr_hit  = 3'b111;
    step(4);
    thr_hit = 3'b100;
    watch(200);
    thr_hit = 3'h0;
    chk_cnt("veto_open", 0, ng);
    fork
      cpd_enc_model_inst.readout(300);
      begin
        step(20);
        thr_hit = 3'b011;
        step(4);
        thr_hit = 3'h0;
        watch(200);
        chk_bit("busy_forced", 1'b1, busy);
      end
    join
    chk_cnt("busy_open", 0, ng);
    step(5);
    chk_bit("busy_clear", 1'b0, busy);
    repeat (3) begin
      rnd = lfsr(rnd);
      k = int'(rnd[2:0]) % 5 + 1;
      m = (rnd[4:3] == 2'h0) ? 2'b01 : rnd[4:3];
      shaper_act = m;
      exp_q.push_back(k * int'(m[0]));
      exp_q.push_back(k * int'(m[1]));
      t = 0;
      while (busy !== 1'b1 && t < 900) begin
        step(1);
        t++;
      end
      chk_bit("settle", 1'b1, t >= 499 && t <= 752);
      step(250 * k + 125);
      shaper_act = 2'h0;
      step(100);
      chk_cnt("burst0", exp_q.pop_front(), cpd_enc_model_inst.scaler[0]);
      chk_cnt("burst1", exp_q.pop_front(), cpd_enc_model_inst.scaler[1]);
      cpd_enc_model_inst.readout(10);
      step(5);
      chk_bit("busy_end", 1'b0, busy);
    end
    wrap_up;
  end
endmodule
